// *** hw/fwp_consts.vh ***
`ifndef FWP_CONSTS_VH
`define FWP_CONSTS_VH
`define FWP_ADDR_CTRL     4'h0
`define FWP_ADDR_STATUS   4'h1
`define FWP_ADDR_COUNT    4'h2
`define FWP_ADDR_OFFSET   4'h3
`define FWP_ADDR_RDDATA   4'h4
`define FWP_ADDR_RDPTR    4'h5
`define FWP_CTRL_ASYNC    0
`define FWP_CTRL_HSTL     1
`define FWP_CTRL_OFFSEL   2
`define FWP_CTRL_RST      3'h0
`define FWP_WORD_W        36
`define FWP_ADDR_LSB      2
`define FWP_ADDR_MSB      5
`endif

// *** hw/fwp_sync2.v ***
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a bus of independent level signals
module fwp_sync2 #(
   parameter W = 1
) (
   input  wire         hclk,
   input  wire         hresetn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end
   assign q = sync_ff;
endmodule
`default_nettype wire

// *** hw/fwp_write_port.v ***
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fwp_consts.vh"
// Overview of operation
// - Sync mode: low enable qualifies clock for memory and offset.
// - Sync mode: word captured on clock rise with enable low.
// - Async mode: every rising strobe edge stores a word while the FIFO is not full and the inputs are not disabled.
// - HSTL mode: chip select high disables the data inputs.
module fwp_write_port #(
   parameter DW    = `FWP_WORD_W,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire          hclk,
   input  wire          hresetn,
   input  wire          hsel,
   input  wire [31:0]   haddr,
   input  wire [1:0]    htrans,
   input  wire          hwrite,
   input  wire [2:0]    hsize,
   input  wire [31:0]   hwdata,
   input  wire          hready,
   output wire          hreadyout,
   output wire          hresp,
   output reg  [31:0]   hrdata,
   input  wire          wr_clk_pin,
   input  wire          wr_strobe_pin,
   input  wire          wr_en_n_pin,
   input  wire          write_chip_select_n,
   input  wire [DW-1:0] wr_data_pin
);
   localparam NSYNC = DW + 4;
   wire [NSYNC-1:0] pin_raw;
   wire [NSYNC-1:0] pin_s;
   wire [DW-1:0]    data_s;
   wire             clk_s;
   wire             stb_s;
   wire             en_n_s;
   wire             cs_n_s;

   // Pins are asynchronous to hclk; the port's edges are sampled here,
   // so the external write clock must run well below hclk/2.
   assign pin_raw = {write_chip_select_n, wr_en_n_pin, wr_strobe_pin,
                     wr_clk_pin, wr_data_pin};
   fwp_sync2 #(.W(NSYNC)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (pin_raw),
      .q       (pin_s)
   );
   assign data_s = pin_s[DW-1:0];
   assign clk_s  = pin_s[DW];
   assign stb_s  = pin_s[DW+1];
   assign en_n_s = pin_s[DW+2];
   assign cs_n_s = pin_s[DW+3];

   // Fill level is one bit wider than the pointers so that
   // a full FIFO and an empty one can be told apart
   reg [2:0]      ctrl_ff;
   reg [2:0]      nxt_ctrl;
   reg [DW-1:0]   mem [0:DEPTH-1];
   reg [AW-1:0]   wptr_ff;
   reg [AW-1:0]   nxt_wptr;
   reg [AW-1:0]   rptr_ff;
   reg [AW-1:0]   nxt_rptr;
   reg [AW:0]     count_ff;
   reg [AW:0]     nxt_count;
   reg [DW-1:0]   offset_ff;
   reg [DW-1:0]   nxt_offset;
   reg            full_drop_ff;
   reg            nxt_full_drop;
   reg            ignored_ff;
   reg            nxt_ignored;

   localparam [AW-1:0] PTR_ONE  = {{(AW-1){1'b0}}, 1'b1};
   localparam [AW:0]   LVL_ONE  = {{AW{1'b0}}, 1'b1};
   localparam [AW:0]   LVL_ZERO = {(AW+1){1'b0}};

   wire async_mode = ctrl_ff[`FWP_CTRL_ASYNC];
   wire hstl_mode  = ctrl_ff[`FWP_CTRL_HSTL];
   wire to_offset  = ctrl_ff[`FWP_CTRL_OFFSEL];

   // Rising-edge detectors for the sampled write clock and strobe.
   // They reset low, the idle level of both pins, so that no false
   // edge follows reset.
   localparam NEDGE = 2;
   wire [NEDGE-1:0] edge_in = {stb_s, clk_s};
   wire [NEDGE-1:0] edge_rise;
   genvar gi;
   generate
      for (gi = 0; gi < NEDGE; gi = gi + 1) begin : g_edge
         reg last_ff;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               last_ff <= 1'b0;
            end else begin
               last_ff <= edge_in[gi];
            end
         end
         assign edge_rise[gi] = edge_in[gi] & ~last_ff;
      end
   endgenerate
   wire clk_rise = edge_rise[0];
   wire stb_rise = edge_rise[1];

   // chip select gating
   // Gated data is forced to zero so a disabled port cannot
   // leak a half-sampled word into memory or the offset register.
   wire          inputs_off = hstl_mode & cs_n_s;
   wire [DW-1:0] data_g     = inputs_off ? {DW{1'b0}} : data_s;

   wire sync_wr  = ~async_mode & clk_rise & ~en_n_s;
   // strobe rising edge
   // The enable pin is not looked at in this mode at all.
   wire async_wr = async_mode & stb_rise;
   wire pin_wr   = sync_wr | async_wr;
   wire port_wr  = pin_wr & ~inputs_off;
   // offset load only in sync mode
   wire off_sel  = to_offset & ~async_mode;
   wire mem_wr   = port_wr & ~off_sel;
   wire off_wr   = port_wr & off_sel;
   wire empty    = (count_ff == LVL_ZERO);
   wire full     = (count_ff == DEPTH);

   // AHB-Lite slave: zero wait states, always OKAY.
   // Only whole-word transfers are used, so hsize is not decoded.
   reg        dph_ff;
   reg        dwr_ff;
   reg [3:0]  dreg_ff;
   wire       ahb_go = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function is_reg;
      input [3:0] a;
      input [3:0] r;
      begin
         is_reg = (a == r);
      end
   endfunction

   // Register selects, all decoded in the data phase
   wire rd_phase = dph_ff & ~dwr_ff;
   wire wr_ctrl  = dph_ff & dwr_ff & is_reg(dreg_ff, `FWP_ADDR_CTRL);
   wire rd_pop   = rd_phase & is_reg(dreg_ff, `FWP_ADDR_RDDATA);
   // Reading an empty FIFO returns whatever the slot holds, no pop
   wire pop      = rd_pop & ~empty;
   // A full FIFO drops the word rather than overwrite the oldest one
   wire push     = mem_wr & ~full;
   wire inc_up   = push & ~pop;
   wire inc_dn   = pop & ~push;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_ff <= 1'b0;
      end else begin
         dph_ff <= ahb_go;
      end
   end

   // Address and direction are held from the last real transfer only,
   // which keeps the decode quiet while the bus idles
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dwr_ff  <= 1'b0;
         dreg_ff <= 4'h0;
      end else if (ahb_go) begin
         dwr_ff  <= hwrite;
         dreg_ff <= haddr[`FWP_ADDR_MSB:`FWP_ADDR_LSB];
      end
   end

   // Next-state logic; pointers wrap at DEPTH, which must be 2**AW
   always @* begin
      nxt_ctrl      = ctrl_ff;
      nxt_wptr      = wptr_ff;
      nxt_rptr      = rptr_ff;
      nxt_count     = count_ff;
      nxt_offset    = offset_ff;
      nxt_full_drop = full_drop_ff;
      nxt_ignored   = ignored_ff;
      if (wr_ctrl) begin
         nxt_ctrl = hwdata[`FWP_CTRL_OFFSEL:`FWP_CTRL_ASYNC];
      end
      if (push) begin
         nxt_wptr = wptr_ff + PTR_ONE;
      end
      if (pop) begin
         nxt_rptr = rptr_ff + PTR_ONE;
      end
      if (inc_up) begin
         nxt_count = count_ff + LVL_ONE;
      end else if (inc_dn) begin
         nxt_count = count_ff - LVL_ONE;
      end
      if (off_wr) begin
         nxt_offset = data_g;
      end
      // Sticky flags: a new event wins over the clearing write
      if (mem_wr & full) begin
         nxt_full_drop = 1'b1;
      end else if (wr_ctrl) begin
         nxt_full_drop = 1'b0;
      end
      if (pin_wr & inputs_off) begin
         nxt_ignored = 1'b1;
      end else if (wr_ctrl) begin
         nxt_ignored = 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `FWP_CTRL_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_ff <= {AW{1'b0}};
      end else begin
         wptr_ff <= nxt_wptr;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rptr_ff <= {AW{1'b0}};
      end else begin
         rptr_ff <= nxt_rptr;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_ff <= LVL_ZERO;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // The offset register keeps its value until the next sync load
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         offset_ff <= {DW{1'b0}};
      end else begin
         offset_ff <= nxt_offset;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         full_drop_ff <= 1'b0;
      end else begin
         full_drop_ff <= nxt_full_drop;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ignored_ff <= 1'b0;
      end else begin
         ignored_ff <= nxt_ignored;
      end
   end

   // Storage has no reset; only slots below the fill level are valid
   always @(posedge hclk) begin
      if (push) begin
         mem[wptr_ff] <= data_g;
      end
   end

   // Read mux; zero outside a read data phase
   always @* begin
      hrdata = 32'h0000_0000;
      if (rd_phase) begin
         case (dreg_ff)
            `FWP_ADDR_CTRL:   hrdata = {29'h0, ctrl_ff};
            `FWP_ADDR_STATUS: hrdata = {27'h0, inputs_off, ignored_ff,
                                        full_drop_ff, full, empty};
            `FWP_ADDR_COUNT:  hrdata = {{(31-AW){1'b0}}, count_ff};
            `FWP_ADDR_OFFSET: hrdata = offset_ff[31:0];
            `FWP_ADDR_RDDATA: hrdata = mem[rptr_ff][31:0];
            `FWP_ADDR_RDPTR:  hrdata = {28'h0, mem[rptr_ff][DW-1:32]};
            default:          hrdata = 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** tb/fwp_write_port_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module fwp_mon (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata
);
   logic       rd_ff;
   logic [3:0] reg_ff;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ff  <= 1'b0;
         reg_ff <= 4'h0;
      end else begin
         rd_ff  <= hsel & htrans[1] & hready & !hwrite;
         reg_ff <= haddr[5:2];
      end
   end
   // The fill level can never pass the depth of 16 words
   a_count_bound: assert property (rd_ff && reg_ff == 4'h2 |->
      hrdata <= 32'h10) else $error("fill level above depth");
   a_ready_high: assert property (hreadyout) else $error("wait state");
   a_resp_okay: assert property (!hresp) else $error("error response");
   // Stale read data would hide a missed pop
   a_rdata_idle: assert property (!rd_ff |-> hrdata == 32'h0)
      else $error("hrdata outside read phase");
endmodule
bind fwp_write_port fwp_mon u_mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// *** tb/fwp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module fwp_host (
   input  wire logic   hclk,
   output logic        clk_o,
   output logic        stb_o,
   output logic        en_n_o,
   output logic        cs_n_o,
   output logic [35:0] d_o
);
   initial {clk_o, stb_o, en_n_o, cs_n_o, d_o} = {4'h2, 36'h0};
   task automatic put(input logic as, en_n, cs_n, input logic [35:0] d);
      @(posedge hclk);
      en_n_o <= en_n & !as;
      cs_n_o <= cs_n;
      d_o <= d;
      repeat (4) @(posedge hclk);
      stb_o <= as;
      clk_o <= !as;
      repeat (4) @(posedge hclk);
      {stb_o, clk_o} <= 2'h0;
      repeat (4) @(posedge hclk);
      // Hold time over, data no longer valid
      d_o <= ~d;
      repeat (8) @(posedge hclk);
   endtask
endmodule
`default_nettype wire

// *** tb/fwp_write_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fwp_write_port_tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic        rdy, resp, wclk, wstb, wen_n, wcs_n;
   logic [35:0] wd, w;
   int          bad_count = 0, num_checks = 0;
   always #25 hclk = ~hclk;
   fwp_write_port u_fwp_write_port (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
      .hresp(resp), .hrdata(hrdata), .wr_clk_pin(wclk),
      .wr_strobe_pin(wstb), .wr_en_n_pin(wen_n),
      .write_chip_select_n(wcs_n), .wr_data_pin(wd));
   fwp_host u_fwp_host (.hclk(hclk), .clk_o(wclk), .stb_o(wstb),
      .en_n_o(wen_n), .cs_n_o(wcs_n), .d_o(wd));
   function automatic logic [31:0] cnt(input logic [2:0] m,
                                       input logic en_n, cs_n);
      return {31'h0, (m[0] | (!en_n & !m[2])) & !(m[1] & cs_n)};
   endfunction
   // Status after one pin write into an empty FIFO, flags cleared
   function automatic logic [31:0] stat(input logic [2:0] m,
                                        input logic en_n, cs_n);
      logic off, hit;
      off = m[1] & cs_n;
      hit = m[0] | !en_n;
      return {27'h0, off, hit & off, 2'h0, cnt(m, en_n, cs_n) == 0};
   endfunction
   task automatic chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, d);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {3'h6, a, wr};
      do @(posedge hclk); while (!rdy);
      {hsel, htrans, hwdata} <= {3'h0, d};
      do @(posedge hclk); while (!rdy);
      rd = hrdata;
   endtask
   task automatic run(input logic [2:0] m, input logic en_n, cs_n);
      w = 36'({$urandom, $urandom});
      bus(1, 32'h0, {29'h0, m});
      u_fwp_host.put(m[0], en_n, cs_n, w);
      bus(0, 32'h8, 0);
      chk(rd, cnt(m, en_n, cs_n));
      bus(0, 32'h4, 0);
      chk(rd, stat(m, en_n, cs_n));
      if (!m[0] && m[2] && !en_n && !(m[1] && cs_n)) begin
         bus(0, 32'hc, 0);
         chk(rd, w[31:0]);
      end
      if (cnt(m, en_n, cs_n) != 0) begin
         bus(0, 32'h14, 0);
         chk(rd, {28'h0, w[35:32]});
         bus(0, 32'h10, 0);
         chk(rd, w[31:0]);
      end
   endtask
   // Seventeen writes into a depth of sixteen: the last one is dropped
   task automatic fill_drain;
      logic [35:0] q [16];
      logic [35:0] x;
      bus(1, 32'h0, 32'h0);
      for (int i = 0; i < 17; i++) begin
         x = 36'({$urandom, $urandom});
         if (i < 16) q[i] = x;
         u_fwp_host.put(1'b0, 1'b0, 1'b0, x);
      end
      bus(0, 32'h8, 0);
      chk(rd, 32'h10);
      bus(0, 32'h4, 0);
      chk(rd, 32'h6);
      for (int i = 0; i < 16; i++) begin
         bus(0, 32'h14, 0);
         chk(rd, {28'h0, q[i][35:32]});
         bus(0, 32'h10, 0);
         chk(rd, q[i][31:0]);
      end
      bus(0, 32'h4, 0);
      chk(rd, 32'h5);
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(85313));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      run(3'h0, 1, 0);
      run(3'h4, 0, 0);
      run(3'h4, 1, 0);
      run(3'h0, 0, 1);
      run(3'h1, 1, 0);
      run(3'h3, 0, 1);
      run(3'h2, 0, 0);
      fill_drain;
      repeat (5) run(3'($urandom), 1'($urandom), 1'($urandom));
      bus(0, 32'h3c, 0);
      chk(rd, 32'h0);
      // Reset in mid-run with a word stored: FIFO and control clear
      u_fwp_host.put(1'b0, 1'b0, 1'b0, 36'h1);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, 32'h8, 0);
      chk(rd, 32'h0);
      bus(0, 32'h0, 0);
      chk(rd, 32'h0);
      print_verdict;
   end
   // About 900 cycles of tests; the limit allows 4,000
   initial begin
      #200000;
      bad_count++;
      print_verdict;
   end
endmodule
`default_nettype wire
